// >>> verification/eac_access_chk.sv
// Purpose: Port-level assertions for the storage access controller
// Assumes: Bench keeps global and ready enables set around writes
// Notes:   Bound to the top module at the foot of this file
`timescale 1ns/1ps
module eac_access_chk #(
    parameter int WRITE_RC_CYCLES = 2048
)(
    input wire logic       clock,
    input wire logic       rst_b,
    input wire logic       pwrOnRst_b,
    input wire logic [5:0] ioAddr,
    input wire logic       ioWrEn,
    input wire logic       ioRdEn,
    input wire logic [7:0] ioWrData,
    input wire logic [7:0] ioRdData,
    input wire logic       globalIntEnable,
    input wire logic       rcTick,
    input wire logic       cpuStall,
    input wire logic       readyIrq
);
    logic [11:0] tickCnt_r;
    logic        rieSeen_r;
    wire         ctrlWr = ioWrEn && ioAddr == 6'h1c;
    wire         busyW  = globalIntEnable && rieSeen_r && !readyIrq;
    // Ticks while ready is low; it spans a write, even across a core reset
    always_ff @(posedge clock)
        tickCnt_r <= (!pwrOnRst_b || readyIrq) ? 12'h0
                     : tickCnt_r + {11'h0, rcTick};
    // Shadow of the ready enable, so busy is told from disabled
    always_ff @(posedge clock)
        rieSeen_r <= !rst_b ? 1'b0 : (ctrlWr ? ioWrData[3] : rieSeen_r);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b || !pwrOnRst_b);
    property p_hi_zero; ioRdEn && ioAddr == 6'h1c |=> ioRdData[7:4] == 4'h0;
    endproperty
    a_hi_zero: assert property (p_hi_zero)
        else $error("control upper bits not zero");
    property p_irq_gate; readyIrq |-> globalIntEnable && rieSeen_r; endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("ready request without enables");
    property p_wr_go;
        ctrlWr && ioWrData[2] && readyIrq ##1 !ioWrEn ##1
        ctrlWr && ioWrData == 8'h0a
        |=> cpuStall[*2] ##1 !cpuStall && !readyIrq;
    endproperty
    a_wr_go: assert property (p_wr_go)
        else $error("armed write did not start as expected");
    property p_arm_lapse;
        ctrlWr && ioWrData[2] && readyIrq ##1 !ioWrEn[*4] ##1
        ctrlWr && ioWrData == 8'h0a |=> !cpuStall && readyIrq;
    endproperty
    a_arm_lapse: assert property (p_arm_lapse)
        else $error("write started after arm window");
    property p_rd_go;
        ctrlWr && ioWrData == 8'h09 && readyIrq && !cpuStall
        |=> cpuStall[*4] ##1 !cpuStall;
    endproperty
    a_rd_go: assert property (p_rd_go)
        else $error("read stall not four cycles");
    property p_tick_total;
        $rose(readyIrq) && $past(globalIntEnable) && !$past(ioWrEn)
        |-> tickCnt_r == 12'(WRITE_RC_CYCLES);
    endproperty
    a_tick_total: assert property (p_tick_total)
        else $error("write length not the tick count");
    property p_rd_blocked;
        busyW && !cpuStall && ctrlWr && ioWrData[0] |=> !cpuStall;
    endproperty
    a_rd_blocked: assert property (p_rd_blocked)
        else $error("read started during write");
    property p_stall_min; $rose(cpuStall) |-> cpuStall[*2]; endproperty
    a_stall_min: assert property (p_stall_min)
        else $error("stall shorter than two cycles");
    property p_stall_max; cpuStall[*4] |=> !cpuStall; endproperty
    a_stall_max: assert property (p_stall_max)
        else $error("stall longer than four cycles");
endmodule

bind eeprom_access_control eac_access_chk #(
    .WRITE_RC_CYCLES(WRITE_RC_CYCLES)
) u_chk (
    .clock(clock), .rst_b(rst_b), .pwrOnRst_b(pwrOnRst_b), .ioAddr(ioAddr),
    .ioWrEn(ioWrEn), .ioRdEn(ioRdEn), .ioWrData(ioWrData),
    .ioRdData(ioRdData), .globalIntEnable(globalIntEnable),
    .rcTick(rcTick), .cpuStall(cpuStall), .readyIrq(readyIrq)
);

// >>> verification/eac_rc_osc_model.sv
// Purpose: Calibrated RC oscillator seen as a tick source
// Assumes: Ticks arrive one clock wide, already synchronised
// Notes:   slow stretches the period like a cold oscillator
`timescale 1ns/1ps
module eac_rc_osc_model (
    input  wire logic clock,
    input  wire logic slow,
    output logic      rcTick
);
    logic [2:0] divCnt_r = 3'h0;
    // Free running: resets never stop the oscillator
    always_ff @(posedge clock)
        divCnt_r <= (divCnt_r >= (slow ? 3'h6 : 3'h2)) ? 3'h0
                    : divCnt_r + 3'h1;
    assign rcTick = (divCnt_r == 3'h0);
endmodule

// >>> verification/test_eeprom_access_control.sv
// Purpose: Self-checking bench for the storage access controller
// Assumes: Write length shortened to 8 ticks
// Notes:   Stall lengths are fixed, so the bench waits them out
`timescale 1ns/1ps
module test_eeprom_access_control;
    logic       clock           = 1'b0;
    logic       rst_b           = 1'b0;
    logic       pwrOnRst_b      = 1'b0;
    logic [5:0] ioAddr          = 6'h00;
    logic       ioWrEn          = 1'b0;
    logic       ioRdEn          = 1'b0;
    logic [7:0] ioWrData        = 8'h00;
    logic       globalIntEnable = 1'b1;
    logic       slow            = 1'b0;
    logic [7:0] ioRdData;
    logic       rcTick;
    logic       cpuStall;
    logic       readyIrq;
    logic [7:0] got;
    int         failures        = 0;
    int         cmpCount        = 0;
    always #10 clock = ~clock;
    eac_rc_osc_model osc (.clock(clock), .slow(slow), .rcTick(rcTick));
    eeprom_access_control #(.WRITE_RC_CYCLES(8)) dut (
        .clock(clock), .rst_b(rst_b), .pwrOnRst_b(pwrOnRst_b),
        .ioAddr(ioAddr), .ioWrEn(ioWrEn), .ioRdEn(ioRdEn),
        .ioWrData(ioWrData), .ioRdData(ioRdData),
        .globalIntEnable(globalIntEnable), .rcTick(rcTick),
        .cpuStall(cpuStall), .readyIrq(readyIrq));
    task automatic conclude;
        if (failures == 0 && cmpCount > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] exp, input logic [7:0] act);
        cmpCount++;
        if (act !== exp)
        begin
            failures++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, act);
        end
    endtask
    // One-cycle bus pulses; a gap cycle follows each one
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock);
        ioAddr   <= a;
        ioWrData <= d;
        ioWrEn   <= 1'b1;
        @(posedge clock);
        ioWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a);
        @(posedge clock);
        ioAddr <= a;
        ioRdEn <= 1'b1;
        @(posedge clock);
        ioRdEn <= 1'b0;
        @(negedge clock);
        got = ioRdData;
    endtask
    // Arm, then strobe after gap extra idle cycles; high bits junk on purpose
    // Bench raises no interrupts, so nothing cuts the arm window
    task automatic prog(input logic [9:0] a, input logic [7:0] d,
                        input int gap);
        wr(6'h1f, {6'h3f, a[9:8]});
        wr(6'h1e, a[7:0]);
        wr(6'h1d, d);
        wr(6'h1c, 8'h0c);
        repeat (gap) @(posedge clock);
        wr(6'h1c, 8'h0a);
        repeat (3) @(posedge clock);
    endtask
    // Bounded poll of the write strobe; a hang shows as a mismatch
    task automatic waitIdle;
        for (int i = 0; i < 100; i++)
        begin
            rd(6'h1c);
            if (got[1] === 1'b0)
                return;
        end
        chk(8'h00, got);
    endtask
    task automatic fetch(input logic [9:0] a);
        int stallSeen;
        stallSeen = 0;
        wr(6'h1f, {6'h00, a[9:8]});
        wr(6'h1e, a[7:0]);
        wr(6'h1c, 8'h09);
        // Count stalled cycles at mid-cycle, where the level is settled
        repeat (6)
        begin
            @(negedge clock);
            stallSeen += int'(cpuStall);
        end
        chk(8'h04, 8'(stallSeen));
        rd(6'h1d);
    endtask
    task automatic s_regs;
        rd(6'h1c);
        chk(8'h00, got);
        wr(6'h1c, 8'hf8);
        rd(6'h1c);
        chk(8'h08, got);
        chk(8'h01, {7'h0, readyIrq});
        @(posedge clock);
        globalIntEnable <= 1'b0;
        @(negedge clock);
        chk(8'h00, {7'h0, readyIrq});
        @(posedge clock);
        globalIntEnable <= 1'b1;
        rd(6'h05);
        chk(8'h00, got);
    endtask
    task automatic s_write_read;
        prog(10'h3ff, 8'ha5, 0);
        rd(6'h1c);
        chk(8'h0a, got);
        waitIdle;
        chk(8'h08, got);
        rd(6'h1f);
        chk(8'h03, got);
        fetch(10'h3ff);
        chk(8'ha5, got);
        rd(6'h1c);
        chk(8'h08, got);
    endtask
    task automatic s_arm;
        prog(10'h000, 8'h11, 2);
        waitIdle;
        prog(10'h000, 8'h3c, 3);
        rd(6'h1c);
        chk(8'h08, got);
        fetch(10'h000);
        chk(8'h11, got);
    endtask
    task automatic s_block;
        slow <= 1'b1;
        prog(10'h155, 8'h77, 0);
        wr(6'h1e, 8'h00);
        wr(6'h1c, 8'h09);
        rd(6'h1e);
        chk(8'h55, got);
        rd(6'h1d);
        chk(8'h77, got);
        waitIdle;
        fetch(10'h155);
        chk(8'h77, got);
        slow <= 1'b0;
    endtask
    task automatic s_reset_mid;
        prog(10'h2aa, 8'hc3, 0);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        rd(6'h1c);
        chk(8'h02, got);
        waitIdle;
        fetch(10'h2aa);
        chk(8'hc3, got);
    endtask
    initial
    begin
        repeat (8) @(posedge clock);
        rst_b      <= 1'b1;
        pwrOnRst_b <= 1'b1;
        s_regs;
        s_write_read;
        s_arm;
        s_block;
        s_reset_mid;
        conclude;
    end
    // Watchdog well beyond the few hundred cycles the run needs
    initial
    begin
        repeat (20000) @(posedge clock);
        failures++;
        conclude;
    end
endmodule

// >>> verilog/eac_defines.svh
// Purpose: Constants for the storage access controller
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef EAC_DEFINES_SVH
`define EAC_DEFINES_SVH

// ----------------------------------------------------------------
// I/O space offsets
// ----------------------------------------------------------------
`define EAC_CTRL_OFS        6'h1c
`define EAC_DATA_OFS        6'h1d
`define EAC_ADDRL_OFS       6'h1e
`define EAC_ADDRH_OFS       6'h1f

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define EAC_RIE_BIT         3
`define EAC_ARM_BIT         2
`define EAC_WS_BIT          1
`define EAC_RS_BIT          0

// ----------------------------------------------------------------
// Timing counts and sizes
// ----------------------------------------------------------------
`define EAC_ARM_CYCLES      3'h4
`define EAC_RD_STALL        3'h4
`define EAC_WR_STALL        3'h2
`define EAC_WRITE_RC_CYCLES 2048
`define EAC_MEM_DEPTH       1024
`define EAC_ADDR_W          10
`define EAC_DATA_W          8

`endif

// >>> verilog/eac_mem_if.sv
// Purpose: Carrier between access logic and storage array
// Assumes: One clock, synchronous read data
// Notes:   Read data is valid the cycle after rdEn
`timescale 1ns/1ps
`include "eac_defines.svh"

interface eac_mem_if;
    logic                      wrEn;
    logic                      rdEn;
    logic [`EAC_ADDR_W-1:0]    addr;
    logic [`EAC_DATA_W-1:0]    wrData;
    logic [`EAC_DATA_W-1:0]    rdData;

    modport ctrl (output wrEn, output rdEn, output addr, output wrData,
                  input rdData);
    modport mem  (input wrEn, input rdEn, input addr, input wrData,
                  output rdData);
endinterface

// >>> verilog/eac_pkg.sv
// Purpose: Types for the storage access controller
// Assumes: Nothing is imported; users write eac_pkg::name
// Notes:   One-hot state codes are written out
package eac_pkg;

    // Access engine state, one hot
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_PROG = 3'b100
    } eac_state_t;

endpackage

// >>> verilog/eac_storage_mem.sv
// Purpose: Byte array that keeps its contents across resets
// Assumes: At most one of wrEn and rdEn per cycle
// Notes:   No reset on the array or the read register on purpose
`timescale 1ns/1ps
`include "eac_defines.svh"

module eac_storage_mem #(
    parameter int DEPTH = `EAC_MEM_DEPTH
)(
    input wire logic   clock,
    eac_mem_if.mem     bus
);

    logic [`EAC_DATA_W-1:0] cells [DEPTH];
    logic [`EAC_DATA_W-1:0] rdData_r;

    // ------------------------------------------------------------
    // Array access
    // ------------------------------------------------------------
    // Contents survive reset, as nonvolatile storage would
    always_ff @(posedge clock)
    begin
        if (bus.wrEn)
            cells[bus.addr] <= bus.wrData;
        if (bus.rdEn)
            rdData_r <= cells[bus.addr];
    end

    assign bus.rdData = rdData_r;

endmodule

// >>> verilog/eeprom_access_control.sv
// Purpose: CPU side access control for a 1K byte storage array
// Assumes: I/O strobes and rcTick are synchronous to clock
// Notes:   rcTick is one pulse per calibrated RC oscillator period
`timescale 1ns/1ps
`include "eac_defines.svh"

// Notes on behaviour
// - Data register sources writes, receives reads
// - Control bits 7..4 always read zero
// - Ready request while no write runs, enable and global
// - Write strobe starts write only when armed
// - Arm bit self clears four cycles later
// - Write strobe stays set until programming ends
// - Write start stalls the processor two cycles
// - Read strobe loads data, clears by hardware
// - Read start stalls the processor four cycles
// - During write: reads ignored, address frozen
// - Write lasts 2048 RC oscillator periods
// - Write in progress survives a core reset
// - Ten bit linear address, upper bits zero
module eeprom_access_control #(
    parameter int WRITE_RC_CYCLES = `EAC_WRITE_RC_CYCLES
)(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        pwrOnRst_b,
    input  wire logic [5:0]  ioAddr,
    input  wire logic        ioWrEn,
    input  wire logic        ioRdEn,
    input  wire logic [7:0]  ioWrData,
    output logic      [7:0]  ioRdData,
    input  wire logic        globalIntEnable,
    input  wire logic        rcTick,
    output logic             cpuStall,
    output logic             readyIrq
);

    localparam int TW = $clog2(WRITE_RC_CYCLES);
    localparam logic [TW-1:0] TICK_LAST = TW'(WRITE_RC_CYCLES - 1);

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    eac_pkg::eac_state_t      state_r;
    eac_pkg::eac_state_t      state_nxt;
    logic [TW-1:0]            tickCnt_r;
    logic [2:0]               armCnt_r;
    logic [2:0]               stallCnt_r;
    logic                     rie_r;
    logic [`EAC_ADDR_W-1:0]   addr_r;
    logic [`EAC_DATA_W-1:0]   data_r;
    logic [7:0]               ioRdData_r;

    eac_mem_if memBus ();

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire ctrlWr  = ioWrEn && (ioAddr == `EAC_CTRL_OFS);
    wire dataWr  = ioWrEn && (ioAddr == `EAC_DATA_OFS);
    wire addrLWr = ioWrEn && (ioAddr == `EAC_ADDRL_OFS);
    wire addrHWr = ioWrEn && (ioAddr == `EAC_ADDRH_OFS);

    // ------------------------------------------------------------
    // Status and start conditions
    // ------------------------------------------------------------
    wire isIdle    = (state_r == eac_pkg::ST_IDLE);
    wire progBusy  = (state_r == eac_pkg::ST_PROG);
    wire readBusy  = (state_r == eac_pkg::ST_READ);
    wire armed     = (armCnt_r != 3'h0);
    wire progDone  = progBusy && rcTick && (tickCnt_r == TICK_LAST);
    // Strobe without a live arm is simply dropped
    wire startWrite = ctrlWr && ioWrData[`EAC_WS_BIT] && armed
                      && isIdle;
    // Read request is ignored while programming is under way
    wire startRead  = ctrlWr && ioWrData[`EAC_RS_BIT] && isIdle
                      && !startWrite;
    // Address frozen during a write so the cell cannot move
    wire addrLoadL  = addrLWr && !progBusy;
    wire addrLoadH  = addrHWr && !progBusy;

    // ------------------------------------------------------------
    // Control register read image
    // ------------------------------------------------------------
    wire [7:0] ctrlImage = {4'h0,
                            rie_r, armed, progBusy, readBusy};

    // Read mux, unmapped offsets return zero
    wire [7:0] rdMux =
        (ioAddr == `EAC_CTRL_OFS)  ? ctrlImage :
        (ioAddr == `EAC_DATA_OFS)  ? data_r :
        (ioAddr == `EAC_ADDRL_OFS) ? addr_r[7:0] :
        (ioAddr == `EAC_ADDRH_OFS) ? {6'h00, addr_r[9:8]} :
        8'h00;

    // ------------------------------------------------------------
    // Storage port
    // ------------------------------------------------------------
    // Byte is committed at write start; busy time models programming
    assign memBus.wrEn   = startWrite;
    assign memBus.rdEn   = startRead;
    assign memBus.addr   = addr_r;
    assign memBus.wrData = data_r;

    eac_storage_mem #(
        .DEPTH (`EAC_MEM_DEPTH)
    ) u_mem (
        .clock (clock),
        .bus   (memBus.mem)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Only one operation may be live, so the engine is one machine
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            eac_pkg::ST_IDLE:
            begin
                if (startWrite)
                    state_nxt = eac_pkg::ST_PROG;
                else if (startRead)
                    state_nxt = eac_pkg::ST_READ;
            end
            eac_pkg::ST_READ:
                state_nxt = eac_pkg::ST_IDLE;
            eac_pkg::ST_PROG:
            begin
                if (progDone)
                    state_nxt = eac_pkg::ST_IDLE;
            end
            default:
                state_nxt = eac_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Engine state and RC period count
    // ------------------------------------------------------------
    // Core reset spares a running write; only power-on kills it
    always_ff @(posedge clock)
    begin
        if (!pwrOnRst_b)
        begin
            state_r   <= eac_pkg::ST_IDLE;
            tickCnt_r <= '0;
        end
        else if (!rst_b && !progBusy)
        begin
            state_r   <= eac_pkg::ST_IDLE;
            tickCnt_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            if (startWrite)
                tickCnt_r <= '0;
            else if (progBusy && rcTick)
                tickCnt_r <= tickCnt_r + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Arm window
    // ------------------------------------------------------------
    // Window counts clock edges, so a stray interrupt expires it
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            armCnt_r <= 3'h0;
        else if (ctrlWr && ioWrData[`EAC_ARM_BIT])
            armCnt_r <= `EAC_ARM_CYCLES;
        else if (ctrlWr)
            armCnt_r <= 3'h0;
        else if (armed)
            armCnt_r <= armCnt_r - 3'h1;
    end

    // ------------------------------------------------------------
    // Processor stall
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            stallCnt_r <= 3'h0;
        else if (startRead)
            stallCnt_r <= `EAC_RD_STALL;
        else if (startWrite)
            stallCnt_r <= `EAC_WR_STALL;
        else if (stallCnt_r != 3'h0)
            stallCnt_r <= stallCnt_r - 3'h1;
    end

    assign cpuStall = (stallCnt_r != 3'h0);

    // ------------------------------------------------------------
    // Ready interrupt enable
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            rie_r <= 1'b0;
        else if (ctrlWr)
            rie_r <= ioWrData[`EAC_RIE_BIT];
    end

    // Level request, held while both enables are set and no write is running
    assign readyIrq = rie_r && globalIntEnable && !progBusy;

    // ------------------------------------------------------------
    // Address and data registers
    // ------------------------------------------------------------
    // No reset: software must load an address before access
    always_ff @(posedge clock)
    begin
        if (addrLoadL)
            addr_r[7:0] <= ioWrData;
        if (addrLoadH)
            addr_r[9:8] <= ioWrData[1:0];
    end

    // Fetched byte lands in the cycle the read strobe clears
    always_ff @(posedge clock)
    begin
        if (readBusy)
            data_r <= memBus.rdData;
        else if (dataWr)
            data_r <= ioWrData;
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            ioRdData_r <= 8'h00;
        else if (ioRdEn)
            ioRdData_r <= rdMux;
    end

    assign ioRdData = ioRdData_r;

endmodule
